// ### logic/pwu_shadow.sv
`timescale 1ns/1ps

// ----------------------------------------
// Shared constants and types
// ----------------------------------------
package pwu_pkg;
   localparam int          DATA_W         = 16;
   localparam int          NUM_SHADOW     = 5;
   localparam int          HTRANS_ACT_BIT = 1;
   localparam logic [7:0]  OFS_GEN_CTRL   = 8'h00;
   localparam logic [7:0]  OFS_DEADBAND   = 8'h04;
   localparam logic [7:0]  OFS_OUT_A      = 8'h08;
   localparam logic [7:0]  OFS_OUT_B      = 8'h0C;
   localparam logic [7:0]  OFS_CMP_A      = 8'h10;
   localparam logic [7:0]  OFS_CMP_B      = 8'h14;
   localparam logic [7:0]  OFS_MASTER     = 8'h18;
   localparam logic [7:0]  OFS_PENDING    = 8'h1C;
   localparam int          POS_DB_UPD     = 10;
   localparam int          POS_GENB_UPD   = 8;
   localparam int          POS_GENA_UPD   = 6;
   localparam int          POS_CMPB_UPD   = 5;
   localparam int          POS_CMPA_UPD   = 4;
   localparam int          POS_SYNC_REQ   = 0;
   localparam logic [31:0] GEN_CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] GEN_CTRL_MASK  = 32'h0000_0FF0;
   localparam logic [31:0] BUS_ZERO       = 32'h0000_0000;
   // Shadow slots: dead-band, out A, out B, compare A, compare B
   localparam int          SH_DB          = 0;
   localparam int          SH_GENA        = 1;
   localparam int          SH_GENB        = 2;
   localparam int          SH_CMPA        = 3;
   localparam int          SH_CMPB        = 4;
   localparam logic [7:0]  SH_OFS [NUM_SHADOW] = '{OFS_DEADBAND, OFS_OUT_A, OFS_OUT_B, OFS_CMP_A, OFS_CMP_B};

   typedef enum logic [1:0] {
      UPD_IMMEDIATE = 2'h0,
      UPD_RESERVED  = 2'h1,
      UPD_LOCAL     = 2'h2,
      UPD_GLOBAL    = 2'h3
   } pwu_upd_mode_t;

   typedef struct packed {
      logic        hsel;
      logic [31:0] haddr;
      logic [1:0]  htrans;
      logic        hwrite;
      logic [2:0]  hsize;
      logic [31:0] hwdata;
   } pwu_ahb_req_t;
endpackage

// ----------------------------------------
// One governed register with its shadow
// ----------------------------------------
module pwu_shadow #(
   parameter int W = 16
) (
   input  wire logic                  i_clk_sys,
   input  wire logic                  i_rst,
   input  wire logic                  i_wr,
   input  wire logic [W-1:0]          i_wdata,
   input  wire pwu_pkg::pwu_upd_mode_t i_mode,
   input  wire logic                  i_cnt_zero,
   input  wire logic                  i_global_req,
   output logic [W-1:0]               o_active,
   output logic                       o_pending
);
   typedef struct packed {
      logic [W-1:0] active;
      logic [W-1:0] held;
      logic         pending;
      logic         armed;
   } pwu_sh_st_t;

   pwu_sh_st_t st;
   pwu_sh_st_t next_st;
   logic       is_global;

   assign is_global = (i_mode == pwu_pkg::UPD_GLOBAL);

   always_comb begin
      next_st = st;
      // Counter zero hands the held value over
      if (st.pending && i_cnt_zero && (!is_global || st.armed)) begin
         next_st.active  = st.held;
         next_st.pending = 1'b0;
         next_st.armed   = 1'b0;
      end
      // A request only counts once something waits or is written in the same cycle
      if (is_global && i_global_req && (st.pending || i_wr)) begin
         next_st.armed = 1'b1;
      end
      if (i_wr) begin
         if (i_mode == pwu_pkg::UPD_IMMEDIATE || i_mode == pwu_pkg::UPD_RESERVED) begin
            next_st.active  = i_wdata;
            next_st.pending = 1'b0;
            next_st.armed   = 1'b0;
         end else begin
            // Newest write overwrites any value still waiting
            next_st.held    = i_wdata;
            next_st.pending = 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign o_active  = st.active;
   assign o_pending = st.pending;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);

   sequence wr_local_s;
      i_wr && i_mode == pwu_pkg::UPD_LOCAL;
   endsequence
   sequence quiet_zero_s;
      !i_wr && i_cnt_zero && i_mode == pwu_pkg::UPD_LOCAL;
   endsequence
   sequence req_pending_s;
      st.pending && is_global && i_global_req && !i_wr && !i_cnt_zero;
   endsequence
   sequence global_zero_s;
      !i_wr && i_cnt_zero && is_global;
   endsequence

   immediate_apply_a: assert property (
      i_wr && i_mode == pwu_pkg::UPD_IMMEDIATE |=> o_active == $past(i_wdata) && !o_pending)
      else $error("immediate write not applied next cycle");
   local_zero_a: assert property (
      st.pending ##0 quiet_zero_s |=> o_active == $past(st.held) && !o_pending)
      else $error("local update missed counter zero");
   local_hold_a: assert property (
      st.pending && !i_cnt_zero && !i_wr |=> $stable(o_active) && o_pending)
      else $error("pending value moved without counter zero");
   global_wait_a: assert property (
      st.pending && is_global && !st.armed && !i_global_req && !i_wr |=> $stable(o_active) && o_pending)
      else $error("global update applied without request");
   global_apply_a: assert property (
      req_pending_s ##1 global_zero_s |=> !o_pending && o_active == $past(st.held, 2))
      else $error("global update missed zero after request");
   last_write_a: assert property (
      st.pending && i_wr && i_mode[1] && !i_cnt_zero |=> o_pending && st.held == $past(i_wdata))
      else $error("older pending value was kept");
endmodule

// ### logic/pwu_top.sv
// Overview of operation
// - Mode zero applies writes at once
// - Mode two waits for counter zero
// - Mode three waits request then zero
// - Two-bit mode fields, one-bit for compare A and B, reset zero, RW
// - Compare B mode bit matches compare A
//
// Local design decisions: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps

module pwu_top #(
   parameter int W = pwu_pkg::DATA_W
) (
   input  wire logic                  i_clk_sys,
   input  wire logic                  i_rst,
   input  wire pwu_pkg::pwu_ahb_req_t i_ahb,
   input  wire logic                  i_hready,
   input  wire logic                  i_cnt_zero,
   input  wire logic                  i_global_req,
   output logic [31:0]                o_hrdata,
   output logic                       o_hreadyout,
   output logic                       o_hresp,
   output logic [W-1:0]               o_deadband,
   output logic [W-1:0]               o_out_a_action,
   output logic [W-1:0]               o_out_b_action,
   output logic [W-1:0]               o_compare_a,
   output logic [W-1:0]               o_compare_b,
   output logic [pwu_pkg::NUM_SHADOW-1:0] o_pending
);
   localparam int N = pwu_pkg::NUM_SHADOW;

   typedef struct packed {
      logic [31:0] gen_ctrl;
      logic        dphase;
      logic        dwrite;
      logic [7:0]  daddr;
      logic [31:0] hrdata;
      logic        hreadyout;
   } pwu_top_st_t;

   pwu_top_st_t st;
   pwu_top_st_t next_st;

   logic                   accept;
   logic                   bus_wr;
   logic                   sync_req;
   logic [N-1:0]           sh_wr;
   logic [W-1:0]           sh_active [N];
   logic [N-1:0]           sh_pending;
   pwu_pkg::pwu_upd_mode_t sh_mode [N];

   // ----------------------------------------
   // Bus slave
   // ----------------------------------------
   // One wait state so read data can leave a flop
   assign accept   = i_ahb.hsel && i_ahb.htrans[pwu_pkg::HTRANS_ACT_BIT] && i_hready;
   assign bus_wr   = st.dphase && st.dwrite;
   assign sync_req = i_global_req ||
                     (bus_wr && st.daddr == pwu_pkg::OFS_MASTER && i_ahb.hwdata[pwu_pkg::POS_SYNC_REQ]);

   always_comb begin
      next_st = st;
      next_st.dphase = 1'b0;
      if (accept) begin
         next_st.dphase    = 1'b1;
         next_st.dwrite    = i_ahb.hwrite;
         next_st.daddr     = i_ahb.haddr[7:0];
         next_st.hreadyout = 1'b0;
      end
      if (st.dphase) begin
         next_st.hreadyout = 1'b1;
         next_st.hrdata    = pwu_pkg::BUS_ZERO;
         if (!st.dwrite) begin
            if (st.daddr == pwu_pkg::OFS_GEN_CTRL) begin
               next_st.hrdata = st.gen_ctrl;
            end
            if (st.daddr == pwu_pkg::OFS_PENDING) begin
               next_st.hrdata = {{(32-N){1'b0}}, sh_pending};
            end
            for (int k = 0; k < N; k++) begin
               if (st.daddr == pwu_pkg::SH_OFS[k]) begin
                  next_st.hrdata = {{(32-W){1'b0}}, sh_active[k]};
               end
            end
         end
      end
      // Only the mode fields are kept; other bits read as zero
      if (bus_wr && st.daddr == pwu_pkg::OFS_GEN_CTRL) begin
         next_st.gen_ctrl = i_ahb.hwdata & pwu_pkg::GEN_CTRL_MASK;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         st <= '{gen_ctrl: pwu_pkg::GEN_CTRL_RESET, hreadyout: 1'b1, default: '0};
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------
   // Update mode decode
   // ----------------------------------------
   assign sh_mode[pwu_pkg::SH_DB]   = pwu_pkg::pwu_upd_mode_t'(st.gen_ctrl[pwu_pkg::POS_DB_UPD +: 2]);
   assign sh_mode[pwu_pkg::SH_GENA] = pwu_pkg::pwu_upd_mode_t'(st.gen_ctrl[pwu_pkg::POS_GENA_UPD +: 2]);
   assign sh_mode[pwu_pkg::SH_GENB] = pwu_pkg::pwu_upd_mode_t'(st.gen_ctrl[pwu_pkg::POS_GENB_UPD +: 2]);
   // Compare modes have no immediate choice: clear is local, set is global
   assign sh_mode[pwu_pkg::SH_CMPA] = pwu_pkg::pwu_upd_mode_t'({1'b1, st.gen_ctrl[pwu_pkg::POS_CMPA_UPD]});
   assign sh_mode[pwu_pkg::SH_CMPB] = pwu_pkg::pwu_upd_mode_t'({1'b1, st.gen_ctrl[pwu_pkg::POS_CMPB_UPD]});

   // ----------------------------------------
   // Shadow registers
   // ----------------------------------------
   for (genvar g = 0; g < N; g++) begin : g_sh
      assign sh_wr[g] = bus_wr && st.daddr == pwu_pkg::SH_OFS[g];
      pwu_shadow #(.W(W)) u_sh (
         .i_clk_sys    (i_clk_sys),
         .i_rst        (i_rst),
         .i_wr         (sh_wr[g]),
         .i_wdata      (i_ahb.hwdata[W-1:0]),
         .i_mode       (sh_mode[g]),
         .i_cnt_zero   (i_cnt_zero),
         .i_global_req (sync_req),
         .o_active     (sh_active[g]),
         .o_pending    (sh_pending[g])
      );
   end

   assign o_hrdata       = st.hrdata;
   assign o_hreadyout    = st.hreadyout;
   assign o_hresp        = 1'b0;
   assign o_deadband     = sh_active[pwu_pkg::SH_DB];
   assign o_out_a_action = sh_active[pwu_pkg::SH_GENA];
   assign o_out_b_action = sh_active[pwu_pkg::SH_GENB];
   assign o_compare_a    = sh_active[pwu_pkg::SH_CMPA];
   assign o_compare_b    = sh_active[pwu_pkg::SH_CMPB];
   assign o_pending      = sh_pending;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);

   sequence ctrl_write_s;
      accept && i_ahb.hwrite && i_ahb.haddr[7:0] == pwu_pkg::OFS_GEN_CTRL;
   endsequence

   mode_store_a: assert property (
      ctrl_write_s ##1 1'b1 |=> st.gen_ctrl == ($past(i_ahb.hwdata) & pwu_pkg::GEN_CTRL_MASK))
      else $error("mode fields did not take written value");
   mode_readback_a: assert property (
      accept && !i_ahb.hwrite && i_ahb.haddr[7:0] == pwu_pkg::OFS_GEN_CTRL && !bus_wr
      |=> ##1 o_hreadyout && o_hrdata == $past(st.gen_ctrl))
      else $error("mode fields read back wrong");
   cmpb_mode_a: assert property (
      sh_mode[pwu_pkg::SH_CMPB] == (st.gen_ctrl[pwu_pkg::POS_CMPB_UPD] ? pwu_pkg::UPD_GLOBAL : pwu_pkg::UPD_LOCAL))
      else $error("compare B mode decode wrong");
   bus_wait_a: assert property (
      accept |=> !o_hreadyout ##1 o_hreadyout)
      else $error("data phase not exactly one wait state");
   db_immediate_a: assert property (
      accept && i_ahb.hwrite && i_ahb.haddr[7:0] == pwu_pkg::OFS_DEADBAND
      && sh_mode[pwu_pkg::SH_DB] == pwu_pkg::UPD_IMMEDIATE ##1 !$changed(st.gen_ctrl)
      |=> o_deadband == $past(i_ahb.hwdata[W-1:0]))
      else $error("dead-band immediate write not visible");
endmodule

// ### tb/tb.sv
`timescale 1ns/1ps

module tb;
   localparam int W = 16;
   localparam int N = pwu_pkg::NUM_SHADOW;
   logic                  i_clk_sys;
   logic                  i_rst;
   pwu_pkg::pwu_ahb_req_t i_ahb;
   logic                  i_cnt_zero;
   logic                  i_global_req;
   logic [31:0]           o_hrdata;
   logic                  o_hreadyout;
   logic                  o_hresp;
   logic [N-1:0][W-1:0]   outs;
   logic [N-1:0]          o_pending;
   logic [W-1:0]          cur [N];
   logic [31:0]           rd;
   int                    fails;
   int                    check_count;

   pwu_top #(.W(W)) dut_u (
      .i_clk_sys      (i_clk_sys),
      .i_rst          (i_rst),
      .i_ahb          (i_ahb),
      .i_hready       (o_hreadyout),
      .i_cnt_zero     (i_cnt_zero),
      .i_global_req   (i_global_req),
      .o_hrdata       (o_hrdata),
      .o_hreadyout    (o_hreadyout),
      .o_hresp        (o_hresp),
      .o_deadband     (outs[0]),
      .o_out_a_action (outs[1]),
      .o_out_b_action (outs[2]),
      .o_compare_a    (outs[3]),
      .o_compare_b    (outs[4]),
      .o_pending      (o_pending)
   );

   initial begin
      i_clk_sys = 1'b0;
      forever #50 i_clk_sys = ~i_clk_sys;
   end

   // ----------------------------------------
   // Bus and checking helpers
   // ----------------------------------------
   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Bounded, so a stuck hreadyout ends the run instead of hanging it
   task automatic wait_ready();
      int n;
      n = 0;
      do begin
         @(posedge i_clk_sys);
         n++;
      end while (o_hreadyout !== 1'b1 && n < 20);
      if (o_hreadyout !== 1'b1) begin
         fails++;
         $display("unexpected at %0t: stall seen %h expected %h", $time, o_hreadyout, 1'b1);
         summarize();
      end
   endtask

   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk_sys);
      i_ahb <= '{hsel: 1'b1, haddr: {24'h000000, a}, htrans: 2'h2, hwrite: wr, hsize: 3'h2, hwdata: 32'h0};
      wait_ready();
      i_ahb.htrans <= 2'h0;
      i_ahb.hwdata <= d;
      wait_ready();
      rd = o_hrdata;
      i_ahb.hsel <= 1'b0;
   endtask

   task automatic pulse(input logic zero, input logic req);
      @(posedge i_clk_sys);
      i_cnt_zero   <= zero;
      i_global_req <= req;
      @(posedge i_clk_sys);
      i_cnt_zero   <= 1'b0;
      i_global_req <= 1'b0;
      @(posedge i_clk_sys);
   endtask

   // Request one cycle, zero the very next cycle
   task automatic req_then_zero();
      @(posedge i_clk_sys);
      i_global_req <= 1'b1;
      @(posedge i_clk_sys);
      i_global_req <= 1'b0;
      i_cnt_zero   <= 1'b1;
      @(posedge i_clk_sys);
      i_cnt_zero   <= 1'b0;
      @(posedge i_clk_sys);
   endtask

   task automatic check_outs(input logic [N-1:0] pend);
      for (int i = 0; i < N; i++) begin
         check(32'(outs[i]), 32'(cur[i]));
      end
      check(32'(o_pending), 32'(pend));
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset();
      xfer(1'b0, pwu_pkg::OFS_GEN_CTRL, 32'h0);
      check(rd, pwu_pkg::GEN_CTRL_RESET);
      xfer(1'b0, pwu_pkg::OFS_PENDING, 32'h0);
      check(rd, 32'h0000_0000);
      $display("reset test done");
   endtask

   task automatic t_ctrl();
      xfer(1'b1, pwu_pkg::OFS_GEN_CTRL, 32'hFFFF_FFFF);
      xfer(1'b0, pwu_pkg::OFS_GEN_CTRL, 32'h0);
      check(rd, pwu_pkg::GEN_CTRL_MASK);
      check(32'(o_hresp), 32'h0000_0000);
      xfer(1'b1, pwu_pkg::OFS_GEN_CTRL, 32'h0000_0560);
      xfer(1'b0, pwu_pkg::OFS_GEN_CTRL, 32'h0);
      check(rd, 32'h0000_0560);
      // Reserved code 1 is taken as immediate
      cur[0] = 16'h0A0A;
      xfer(1'b1, pwu_pkg::OFS_DEADBAND, 32'(cur[0]));
      check_outs(5'h00);
      xfer(1'b0, 8'h20, 32'h0);
      check(rd, 32'h0000_0000);
      $display("control test done");
   endtask

   // Modes 0 everywhere; compare bits 0 still wait for zero
   task automatic t_immediate();
      xfer(1'b1, pwu_pkg::OFS_GEN_CTRL, 32'h0000_0000);
      for (int i = 0; i < 3; i++) begin
         cur[i] = 16'h1000 + 16'(i);
         xfer(1'b1, pwu_pkg::SH_OFS[i], 32'(cur[i]));
      end
      check_outs(5'h00);
      $display("immediate test done");
   endtask

   task automatic t_local();
      xfer(1'b1, pwu_pkg::OFS_GEN_CTRL, 32'h0000_0A80);
      for (int i = 0; i < N; i++) begin
         xfer(1'b1, pwu_pkg::SH_OFS[i], 32'h2000 + 32'(i));
      end
      check_outs(5'h1F);
      pulse(1'b1, 1'b0);
      for (int i = 0; i < N; i++) begin
         cur[i] = 16'h2000 + 16'(i);
      end
      check_outs(5'h00);
      $display("local test done");
   endtask

   task automatic t_global();
      xfer(1'b1, pwu_pkg::OFS_GEN_CTRL, 32'h0000_0FF0);
      for (int i = 0; i < N; i++) begin
         xfer(1'b1, pwu_pkg::SH_OFS[i], 32'h3000 + 32'(i));
         xfer(1'b1, pwu_pkg::SH_OFS[i], 32'h4000 + 32'(i));
      end
      pulse(1'b1, 1'b0);
      check_outs(5'h1F);
      xfer(1'b0, pwu_pkg::OFS_DEADBAND, 32'h0);
      check(rd, 32'(cur[0]));
      xfer(1'b1, pwu_pkg::OFS_MASTER, 32'h0000_0001);
      check_outs(5'h1F);
      pulse(1'b1, 1'b0);
      for (int i = 0; i < N; i++) begin
         cur[i] = 16'h4000 + 16'(i);
      end
      check_outs(5'h00);
      xfer(1'b1, pwu_pkg::OFS_OUT_B, 32'h0000_5A5A);
      pulse(1'b0, 1'b1);
      check_outs(5'h04);
      pulse(1'b1, 1'b0);
      cur[2] = 16'h5A5A;
      check_outs(5'h00);
      // Request and zero together only arm; a later zero moves it
      xfer(1'b1, pwu_pkg::OFS_OUT_A, 32'h0000_6B6B);
      pulse(1'b1, 1'b1);
      check_outs(5'h02);
      pulse(1'b1, 1'b0);
      cur[1] = 16'h6B6B;
      check_outs(5'h00);
      xfer(1'b1, pwu_pkg::OFS_CMP_B, 32'h0000_7C7C);
      req_then_zero();
      cur[4] = 16'h7C7C;
      check_outs(5'h00);
      $display("global test done");
   endtask

   initial begin
      i_rst        = 1'b1;
      i_ahb        = '0;
      i_cnt_zero   = 1'b0;
      i_global_req = 1'b0;
      fails        = 0;
      check_count  = 0;
      for (int i = 0; i < N; i++) begin
         cur[i] = '0;
      end
      repeat (10) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      t_reset();
      t_ctrl();
      t_immediate();
      t_local();
      t_global();
      summarize();
   end
endmodule
